/* rtl/sio_sram_pkg.sv */
/*
 * Shared constants and types of the separate-I/O two-word burst SRAM port.
 * Assumes nothing of its surroundings; every design file imports it whole.
 */
package sio_sram_pkg;

    // Default geometry: four nine-bit lanes, two arrays of 256K words each.
    localparam int LANES_DEF = 4;
    localparam int LANE_W_DEF = 9;
    localparam int ADDR_W_DEF = 18;

    // Words per burst and the number of half-depth arrays that hold them.
    localparam int BURST_LEN = 2;

    // Depth of every synchroniser chain.
    localparam int SYNC_STAGES = 2;

    // Level of the direction input while the load strobe is low.
    typedef enum logic {
        DIR_WRITE = 1'b0,
        DIR_READ = 1'b1
    } dir_t;

    // Write burst progress; one bit changes per step, except from commit back to idle.
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_WORD0 = 2'b01,
        WR_COMMIT = 2'b11
    } wr_phase_t;

endpackage

/* rtl/sio_sync.sv */
/*
 * Two-flop level synchroniser into the domain of clk_i.
 * Assumes din_i is a level that stays put for at least two destination edges.
 */
`timescale 1ns/100ps
module sio_sync
    import sio_sram_pkg::*;
(
    input wire logic clk_i,
    input wire logic din_i,
    output logic dout_o
);
    logic [SYNC_STAGES-1:0] chain_q;
    logic [SYNC_STAGES-1:0] chain_d;

    always_comb begin
        chain_d = {chain_q[SYNC_STAGES-2:0], din_i};
    end

    always_ff @(posedge clk_i) begin
        chain_q <= chain_d;
    end

    assign dout_o = chain_q[SYNC_STAGES-1];
endmodule // sio_sync

/* rtl/sio_sram_port.sv */
/*
 * Separate-I/O double-data-rate SRAM with two-word bursts, device side.
 * The link logic runs on the input clock k_clk_i; its falling edge stands for
 * the rising edge of the negative input clock. Read data leaves on the output
 * clock c_clk_i, or on k_clk_i in single clock mode. The sys_clk_i domain
 * holds the user-side configuration and the completion pulses.
 * Assumes c_clk_i has the frequency of k_clk_i, and that single clock mode
 * changes only while the port is idle.
 * Write loads may come on every rise of k_clk_i; a read fetched on the edge
 * at which a write to the same address commits returns the old words.
 * Writes loaded on consecutive rises commit and flip wr_tgl on consecutive edges.
 * The mode and DLL pins are free-running levels and are synchronised first.
 * Memory contents are not reset; a location reads unknown until written.
 * Switching the clock mode with reads in flight may clip an output phase.
 */
// What this block does
// - Write words captured on both input clock rises.
// - Every transaction moves exactly two data words.
// - Byte lane selects sampled with their data word.
// - Each select gates its own fixed lane bits.
// - Deselected lane keeps stored data unchanged.
// - Address sampled only on positive input clock rise.
// - One address bus carries read and write addresses.
// - Deselected port ignores all address inputs.
// - Memory is two arrays of half depth.
// - Read words driven on output clocks, else input.
// - Read outputs float whenever read port is deselected.
// - Every access begins on positive input clock rise.
`timescale 1ns/100ps
module sio_sram_port
    import sio_sram_pkg::*;
#(
    parameter int LANES = LANES_DEF,
    parameter int LANE_W = LANE_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic single_clk_mode_i,
    input wire logic dll_disable_n_i,
    output logic wr_done_o,
    output logic rd_done_o,
    output logic dll_enabled_o,
    input wire logic k_clk_i,
    input wire logic c_clk_i,
    input wire logic load_strobe_n_i,
    input wire logic read_write_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [LANES*LANE_W-1:0] wr_data_i,
    input wire logic [LANES-1:0] byte_lane_write_sel_n_i,
    output logic [LANES*LANE_W-1:0] rd_data_o,
    output logic rd_data_oe_o,
    output logic [1:0] echo_clk_pair_o
);
    localparam int DW = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // Link state on the rising edge of the positive input clock.
    typedef struct packed {
        wr_phase_t wr_phase;
        logic wr_next;
        logic [ADDR_W-1:0] wr_addr;
        logic [ADDR_W-1:0] commit_addr;
        logic [DW-1:0] word0;
        logic [LANES-1:0] sel0_n;
        logic rd_pend;
        logic [ADDR_W-1:0] rd_addr;
        logic rd_vld;
        logic wr_tgl;
        logic rd_tgl;
    } k_state_t;

    // User-side state in the system clock domain.
    typedef struct packed {
        logic single_mode;
        logic dll_en;
        logic wr_seen;
        logic rd_seen;
        logic wr_pulse;
        logic rd_pulse;
    } sys_state_t;

    // Read output state on the rising edge of the output clock.
    typedef struct packed {
        logic [DW-1:0] hi;
        logic [DW-1:0] lo;
        logic oe;
    } out_state_t;

    // Lane enable from the active-low selects; used for both burst words.
    function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] sel_n);
        logic [DW-1:0] m;
        m = '0;
        for (int l = 0; l < LANES; l++) begin
            m[l*LANE_W +: LANE_W] = {LANE_W{~sel_n[l]}};
        end
        return m;
    endfunction

    // Keeps the stored bits of every lane whose select is high.
    function automatic logic [DW-1:0] lane_merge(
        input logic [DW-1:0] old_word,
        input logic [DW-1:0] new_word,
        input logic [LANES-1:0] sel_n
    );
        logic [DW-1:0] m;
        m = lane_mask(sel_n);
        return (new_word & m) | (old_word & ~m);
    endfunction

    k_state_t k_q;
    k_state_t k_d;
    sys_state_t s_q;
    sys_state_t s_d;
    out_state_t o_q;
    out_state_t o_d;

    logic k_rst;
    logic s_single_pin;
    logic s_dll_pin;
    logic k_single_mode;
    logic s_wr_tgl;
    logic s_rd_tgl;
    logic out_clk;
    logic [DW-1:0] word1_q;
    logic [LANES-1:0] sel1_n_q;
    logic [DW-1:0] rd_word0_q;
    logic [DW-1:0] rd_word1_q;

    // Two half-depth arrays: the first holds burst word 0, the second word 1.
    logic [DW-1:0] mem_first [DEPTH];
    logic [DW-1:0] mem_second [DEPTH];

    // System domain: configuration registers and completion pulses.
    always_comb begin
        s_d = s_q;
        s_d.single_mode = s_single_pin;
        s_d.dll_en = s_dll_pin;
        s_d.wr_seen = s_wr_tgl;
        s_d.rd_seen = s_rd_tgl;
        s_d.wr_pulse = s_wr_tgl ^ s_q.wr_seen;
        s_d.rd_pulse = s_rd_tgl ^ s_q.rd_seen;
    end

    // Configuration follows its synchronised pins; the done pulses last one cycle.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wr_done_o = s_q.wr_pulse;
    assign rd_done_o = s_q.rd_pulse;
    assign dll_enabled_o = s_q.dll_en;

    // The mode and DLL pins are asynchronous levels; two flops before use.
    sio_sync u_sync_single_pin (
        .clk_i(sys_clk_i),
        .din_i(single_clk_mode_i),
        .dout_o(s_single_pin)
    );

    sio_sync u_sync_dll_pin (
        .clk_i(sys_clk_i),
        .din_i(dll_disable_n_i),
        .dout_o(s_dll_pin)
    );

    // Crossings between the system domain and the input clock domain.
    sio_sync u_sync_rst (
        .clk_i(k_clk_i),
        .din_i(rst_i),
        .dout_o(k_rst)
    );

    sio_sync u_sync_mode (
        .clk_i(k_clk_i),
        .din_i(s_q.single_mode),
        .dout_o(k_single_mode)
    );

    sio_sync u_sync_wr (
        .clk_i(sys_clk_i),
        .din_i(k_q.wr_tgl),
        .dout_o(s_wr_tgl)
    );

    sio_sync u_sync_rd (
        .clk_i(sys_clk_i),
        .din_i(k_q.rd_tgl),
        .dout_o(s_rd_tgl)
    );

    // Input clock domain: command decode and write burst sequencing.
    always_comb begin
        k_d = k_q;
        k_d.rd_vld = 1'b0;
        k_d.rd_pend = 1'b0;
        k_d.wr_next = 1'b0;
        // First burst word and its selects, one edge after the write load.
        if (k_q.wr_next) begin
            k_d.word0 = wr_data_i;
            k_d.sel0_n = byte_lane_write_sel_n_i;
            k_d.commit_addr = k_q.wr_addr;
        end
        case (k_q.wr_phase)
            WR_IDLE: begin
                k_d.wr_phase = k_q.wr_next ? WR_WORD0 : WR_IDLE;
            end
            WR_WORD0: begin
                // Both words commit on this edge; a write loaded one rise ago follows on.
                k_d.wr_phase = k_q.wr_next ? WR_WORD0 : WR_COMMIT;
                k_d.wr_tgl = ~k_q.wr_tgl;
            end
            WR_COMMIT: begin
                k_d.wr_phase = k_q.wr_next ? WR_WORD0 : WR_IDLE;
            end
            default: begin
                k_d.wr_phase = WR_IDLE;
            end
        endcase
        // With the strobe high the address and direction are not looked at.
        if (!load_strobe_n_i) begin
            if (read_write_i == DIR_READ) begin
                k_d.rd_pend = 1'b1;
                k_d.rd_addr = addr_i;
            end else begin
                k_d.wr_next = 1'b1;
                k_d.wr_addr = addr_i;
            end
        end
        // The toggles cross to the system domain as levels, one change per burst.
        if (k_q.rd_pend) begin
            k_d.rd_vld = 1'b1;
            k_d.rd_tgl = ~k_q.rd_tgl;
        end
    end

    // Reset arrives through a two-flop synchroniser, so it takes effect two edges late.
    always_ff @(posedge k_clk_i) begin
        if (k_rst) begin
            k_q <= '0;
            k_q.wr_phase <= WR_IDLE;
        end else begin
            k_q <= k_d;
        end
    end

    // Second burst word on the rising edge of the negative input clock.
    always_ff @(negedge k_clk_i) begin
        word1_q <= wr_data_i;
        sel1_n_q <= byte_lane_write_sel_n_i;
    end

    // Array commit of both words; a deselected lane keeps its old bits.
    always_ff @(posedge k_clk_i) begin
        if (k_q.wr_phase == WR_WORD0) begin
            mem_first[k_q.commit_addr] <= lane_merge(mem_first[k_q.commit_addr], k_q.word0,
                k_q.sel0_n);
            mem_second[k_q.commit_addr] <= lane_merge(mem_second[k_q.commit_addr], word1_q,
                sel1_n_q);
        end
    end

    // Burst fetch one edge after the read load, both words at once.
    always_ff @(posedge k_clk_i) begin
        if (k_q.rd_pend) begin
            rd_word0_q <= mem_first[k_q.rd_addr];
            rd_word1_q <= mem_second[k_q.rd_addr];
        end
    end

    // Output clock: the C pair, or the K pair in single clock mode.
    assign out_clk = k_single_mode ? k_clk_i : c_clk_i;

    // Idle data is zero, so a floated bus never shows a stale word.
    always_comb begin
        o_d = o_q;
        o_d.oe = k_q.rd_vld;
        o_d.hi = k_q.rd_vld ? rd_word0_q : '0;
        o_d.lo = k_q.rd_vld ? rd_word1_q : '0;
    end

    always_ff @(posedge out_clk) begin
        if (k_rst) begin
            o_q <= '0;
        end else begin
            o_q <= o_d;
        end
    end

    // Word 0 stands in the high half of the output clock, word 1 in the low.
    assign rd_data_o = out_clk ? o_q.hi : o_q.lo;
    assign rd_data_oe_o = o_q.oe;
    assign echo_clk_pair_o = {~out_clk, out_clk};
endmodule // sio_sram_port

/* testbench/sio_sram_port_chk.sv */
/* Pin checker of the SRAM port.
   Assumes binding into sio_sram_port. */
`timescale 1ns/100ps
module sio_sram_port_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic single_clk_mode_i,
    input wire logic dll_disable_n_i,
    input wire logic dll_enabled_o,
    input wire logic wr_done_o,
    input wire logic rd_done_o,
    input wire logic k_clk_i,
    input wire logic c_clk_i,
    input wire logic load_strobe_n_i,
    input wire logic read_write_i,
    input wire logic rd_data_oe_o,
    input wire logic [1:0] echo_clk_pair_o
);
    wire rd_ld = !load_strobe_n_i && read_write_i;
    wire wr_ld = !load_strobe_n_i && !read_write_i;
    wire sm = single_clk_mode_i;
    a_read_single: assert property (@(posedge k_clk_i) disable iff (rst_i)
        rd_ld && sm |-> ##3 rd_data_oe_o) else $error("oe late");
    a_read_out: assert property (@(posedge k_clk_i) disable iff (rst_i)
        rd_ld && !sm |-> ##2 rd_data_oe_o) else $error("oe late");
    a_float_idle: assert property (@(posedge k_clk_i) disable iff (rst_i)
        sm && rd_data_oe_o |-> $past(rd_ld, 3)) else $error("oe stray");
    a_write_float: assert property (@(posedge k_clk_i) disable iff (rst_i)
        wr_ld && sm |-> ##3 !rd_data_oe_o) else $error("oe on write");
    a_echo_pair: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        echo_clk_pair_o[1] == !echo_clk_pair_o[0]) else $error("echo pair");
    a_echo_source: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !$past(rst_i, 16) && $past(sm, 16) == sm |->
        echo_clk_pair_o[0] == (sm ? k_clk_i : c_clk_i)) else $error("echo source");
    a_wr_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_done_o |=> !wr_done_o) else $error("wr pulse");
    a_rd_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rd_done_o |=> !rd_done_o) else $error("rd pulse");
    a_dll_copy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !$past(rst_i) |-> dll_enabled_o == $past(dll_disable_n_i, 3)) else $error("dll copy");
    c_rd_single: cover property (@(posedge k_clk_i) rd_ld && sm);
    c_rd_out: cover property (@(posedge k_clk_i) rd_ld && !sm);
    c_wr: cover property (@(posedge k_clk_i) wr_ld);
endmodule // sio_sram_port_chk
bind sio_sram_port sio_sram_port_chk sio_sram_port_chk_inst (.sys_clk_i, .rst_i,
    .single_clk_mode_i, .dll_disable_n_i, .dll_enabled_o,
    .wr_done_o, .rd_done_o, .k_clk_i, .c_clk_i, .load_strobe_n_i,
    .read_write_i, .rd_data_oe_o, .echo_clk_pair_o);

/* testbench/sio_host.sv */
/* Host controller model on the link side.
   Assumes K from the bench, echo and read data from the port. */
`timescale 1ns/100ps
module sio_host (
    input wire logic k_clk_i,
    input wire logic echo_i,
    input wire logic [35:0] rd_data_i,
    input wire logic oe_i,
    output logic ld_n_o = 1'b1,
    output logic rw_o = 1'b0,
    output logic [17:0] addr_o = '0,
    output logic [35:0] wd_o = '0,
    output logic [3:0] sel_n_o = 4'hF
);
    // Released lines show the inverse, so a stale value can never pass.
    task automatic wr(input logic [17:0] a, input logic [35:0] w0, w1, input logic [7:0] s);
        @(posedge k_clk_i);
        ld_n_o <= 1'b0;
        rw_o <= 1'b0;
        addr_o <= a;
        @(posedge k_clk_i);
        ld_n_o <= 1'b1;
        addr_o <= ~a;
        wd_o <= w0;
        sel_n_o <= s[3:0];
        @(posedge k_clk_i);
        wd_o <= w1;
        sel_n_o <= s[7:4];
        @(posedge k_clk_i);
        wd_o <= ~w1;
        sel_n_o <= ~s[7:4];
    endtask
    task automatic rd(input logic [17:0] a, output logic [35:0] r0, r1, output logic o);
        @(posedge k_clk_i);
        ld_n_o <= 1'b0;
        rw_o <= 1'b1;
        addr_o <= a;
        @(posedge k_clk_i);
        ld_n_o <= 1'b1;
        addr_o <= ~a;
        o = 1'b0;
        for (int n = 0; n < 4 && !o; n++) begin
            @(posedge echo_i);
            #2 o = oe_i;
        end
        r0 = rd_data_i;
        @(negedge echo_i);
        #2 r1 = rd_data_i;
    endtask
endmodule // sio_host

/* testbench/tb_sio_sram_port.sv */
/* Self-checking bench of the SRAM port.
   Assumes package, design and host model compiled first. */
`timescale 1ns/100ps
module tb_sio_sram_port;
    logic sclk = 1'b0, kclk = 1'b0, cclk, rst = 1'b1, single = 1'b1, dll_n = 1'b1;
    logic wr_done, rd_done, ld_n, rw, oe;
    logic [17:0] addr;
    logic [35:0] wd, rq, mem0 [4], mem1 [4];
    logic [3:0] sel_n;
    logic [1:0] echo;
    logic [31:0] seed = 32'h3543E2C6;
    int err_count = 0, cmp_count = 0, wrn = 0, rdn = 0, nops = 0;
    initial forever #4 sclk = ~sclk;
    initial begin
        #1;
        forever #6 kclk = ~kclk;
    end
    assign #2 cclk = kclk;
    sio_sram_port sio_sram_port_inst (.sys_clk_i(sclk), .rst_i(rst), .single_clk_mode_i(single),
        .dll_disable_n_i(dll_n), .wr_done_o(wr_done), .rd_done_o(rd_done), .dll_enabled_o(),
        .k_clk_i(kclk), .c_clk_i(cclk), .load_strobe_n_i(ld_n), .read_write_i(rw),
        .addr_i(addr), .wr_data_i(wd), .byte_lane_write_sel_n_i(sel_n), .rd_data_o(rq),
        .rd_data_oe_o(oe), .echo_clk_pair_o(echo));
    sio_host host (.k_clk_i(kclk), .echo_i(echo[0]), .rd_data_i(rq), .oe_i(oe),
        .ld_n_o(ld_n), .rw_o(rw), .addr_o(addr), .wd_o(wd), .sel_n_o(sel_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [35:0] mrg(logic [35:0] o, n, logic [3:0] s);
        for (int l = 0; l < 4; l++) if (!s[l]) o[9*l+:9] = n[9*l+:9];
        return o;
    endfunction
    task automatic chk(input string n, input logic [35:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sclk) begin
        dll_n <= seed[7];
        if (!rst && wr_done) wrn++;
        if (!rst && rd_done) rdn++;
    end
    initial begin
        logic [63:0] d0, d1;
        logic [35:0] r0, r1;
        logic [31:0] s;
        logic o;
        repeat (20) @(posedge sclk);
        rst <= 1'b0;
        for (int m = 0; m < 2; m++) begin
            @(posedge sclk);
            single <= (m == 0);
            repeat (12) @(posedge kclk);
            for (int i = 0; i < 20; i++) begin
                d0 = {rnd(), rnd()};
                d1 = {rnd(), rnd()};
                s = i < 4 ? 32'h0 : rnd();
                host.wr({2'(i), 16'h5A5A}, d0[35:0], d1[35:0], s[7:0]);
                mem0[i%4] = mrg(mem0[i%4], d0[35:0], s[3:0]);
                mem1[i%4] = mrg(mem1[i%4], d1[35:0], s[7:4]);
                host.rd({2'(i), 16'h5A5A}, r0, r1, o);
                nops++;
                chk("oe", 36'(o), 36'h1);
                chk("word0", r0, mem0[i%4]);
                chk("word1", r1, mem1[i%4]);
            end
            $display("test mode %0d done", m);
        end
        repeat (20) @(posedge sclk);
        chk("writes", 36'(wrn), 36'(nops));
        chk("reads", 36'(rdn), 36'(nops));
        summarize();
    end
    initial begin
        repeat (5000) @(posedge sclk);
        err_count++;
        summarize();
    end
endmodule // tb_sio_sram_port
